// >>> rtl/eil_pkg.sv
package eil_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] EIL_ADDR_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] EIL_ADDR_SYS_CONTROL = 12'h004;
    // ****************************************
    // status and control fields
    // ****************************************
    localparam int EIL_BIT_SENSE = 0;
    localparam int EIL_BIT_MASK = 1;
    localparam int EIL_BIT_ACK = 2;
    localparam int EIL_BIT_PENDING = 3;
    localparam logic [7:0] EIL_STATUS_RESET = 8'h00;
    // ****************************************
    // system control fields
    // ****************************************
    localparam int EIL_BIT_PIN_ENABLE = 0;
    localparam int EIL_BIT_BREAK_CLEAR = 1;
    localparam logic [1:0] EIL_SYS_RESET = 2'h0;
endpackage : eil_pkg

// >>> rtl/eil_top.sv
// Contract
// - pin works as interrupt only when enabled
// - falling pin edge sets the latch
// - vector fetch acknowledge clears the latch
// - reset clears the latch
// - edge-only after reset, select adds level
// - mask withholds latched request from priority logic
// - level mode clears after ack and pin high
// - edge after software ack sets latch again
// - reset clears latch and sense select
// - edge mode ack clears latch at once
// - pending flag bit 3 ignores mask
// - mask bit 1 disables request when one
// - sense bit 0 selects edge plus level
// - unmasked taken request loads vector address
// - latching continues in wait and stop, wakes
// - break clear only with break clear enable
// - global mask blocks this request too
// - bits 7 to 4 read zero, reset zero
//
// Register access over APB and the register addresses were decided locally.
module eil_top
    import eil_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // request pin, active low
    input wire logic IRQ_PIN_N,
    // cpu side
    input wire logic VECTOR_ACK,
    input wire logic CCR_REQUEST_MASK,
    input wire logic BREAK_STATE,
    output logic IRQ_REQ,
    output logic VECTOR_SEL,
    output logic WAKEUP
);
    // ****************************************
    // bus decode
    // ****************************************
    logic wr_en;
    logic rd_en;
    logic hit_sc;
    logic hit_sys;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign hit_sc = (PADDR == EIL_ADDR_STATUS_CONTROL);
    assign hit_sys = (PADDR == EIL_ADDR_SYS_CONTROL);
    // zero wait states; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(hit_sc || hit_sys);

    // ****************************************
    // control bits
    // ****************************************
    logic sense_r;
    logic mask_r;
    logic pin_en_r;
    logic brk_clr_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sense_r <= EIL_STATUS_RESET[EIL_BIT_SENSE];
            mask_r <= EIL_STATUS_RESET[EIL_BIT_MASK];
        end else if (wr_en && hit_sc) begin
            sense_r <= PWDATA[EIL_BIT_SENSE];
            mask_r <= PWDATA[EIL_BIT_MASK];
        end
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_en_r <= EIL_SYS_RESET[EIL_BIT_PIN_ENABLE];
            brk_clr_r <= EIL_SYS_RESET[EIL_BIT_BREAK_CLEAR];
        end else if (wr_en && hit_sys) begin
            pin_en_r <= PWDATA[EIL_BIT_PIN_ENABLE];
            brk_clr_r <= PWDATA[EIL_BIT_BREAK_CLEAR];
        end
    end

    // ****************************************
    // pin synchroniser and edge detect
    // ****************************************
    // the first stage feeds only the second; edges come from stages two and three
    logic sync1_r;
    logic sync2_r;
    logic pin_d_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            pin_d_r <= 1'b1;
        end else begin
            sync1_r <= IRQ_PIN_N;
            sync2_r <= sync1_r;
            pin_d_r <= sync2_r;
        end
    end
    logic pin_low;
    logic fall;
    // a disabled pin reads as idle high so it serves its other functions
    assign pin_low = pin_en_r && !sync2_r;
    assign fall = pin_en_r && pin_d_r && !sync2_r;

    // ****************************************
    // latch
    // ****************************************
    logic sw_ack;
    logic ack;
    logic latch_r;
    logic latch_nxt;
    // in break the software clear is ignored unless allowed
    assign sw_ack = wr_en && hit_sc && PWDATA[EIL_BIT_ACK]
                    && (!BREAK_STATE || brk_clr_r);
    assign ack = sw_ack || VECTOR_ACK;
    always_comb begin
        latch_nxt = latch_r;
        if (ack) begin
            latch_nxt = 1'b0;
        end
        // a new edge wins over a clear in the same cycle
        if (fall) begin
            latch_nxt = 1'b1;
        end
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            latch_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // ****************************************
    // request and status
    // ****************************************
    logic pending;
    // level mode keeps the request up while the pin stays low
    assign pending = latch_r || (sense_r && pin_low);
    assign IRQ_REQ = pending && !mask_r && !CCR_REQUEST_MASK;
    assign VECTOR_SEL = IRQ_REQ;
    assign WAKEUP = pending && !mask_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h0000_0000;
            if (PADDR == EIL_ADDR_STATUS_CONTROL) begin
                PRDATA[EIL_BIT_PENDING] <= pending;
                PRDATA[EIL_BIT_MASK] <= mask_r;
                PRDATA[EIL_BIT_SENSE] <= sense_r;
            end else if (PADDR == EIL_ADDR_SYS_CONTROL) begin
                PRDATA[EIL_BIT_PIN_ENABLE] <= pin_en_r;
                PRDATA[EIL_BIT_BREAK_CLEAR] <= brk_clr_r;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    edge_sets_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        fall |=> latch_r)
        else $error("falling edge did not set latch");
    edge_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (ack && !fall && !sense_r) |=> !pending)
        else $error("edge mode ack did not clear");
    level_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense_r && pin_low) |-> pending)
        else $error("level request dropped while pin low");
    mask_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        mask_r |-> !IRQ_REQ)
        else $error("masked request forwarded");
    global_mask_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        CCR_REQUEST_MASK |-> !IRQ_REQ)
        else $error("global mask ignored");
    break_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (BREAK_STATE && !brk_clr_r && !VECTOR_ACK && latch_r) |=> latch_r)
        else $error("latch cleared in protected break");
    disabled_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (!pin_en_r && !latch_r) |=> !latch_r)
        else $error("disabled pin set latch");
    sync_delay_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (pin_en_r && $fell(IRQ_PIN_N)) ##1 (pin_en_r && !IRQ_PIN_N) |=> fall)
        else $error("edge not seen two cycles later");
endmodule : eil_top

// >>> tb/eil_pin_model.sv
module eil_pin_model (
    // bench control
    input wire logic CLK,
    input wire logic low_req,
    // request pin, pulled up when released
    output logic IRQ_PIN_N
);
    timeunit 1ns;
    timeprecision 1ns;
    initial IRQ_PIN_N = 1'b1;
    // moves after the edge so the synchroniser sees a clean step
    always @(posedge CLK) IRQ_PIN_N <= ~low_req;
endmodule : eil_pin_model

// >>> tb/test_external_interrupt_latch.sv
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t mismatch", $time); end end

module test_external_interrupt_latch
    import eil_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // bench
    // ****************************************
    localparam logic [11:0] SC = EIL_ADDR_STATUS_CONTROL;
    localparam logic [11:0] SY = EIL_ADDR_SYS_CONTROL;
    logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, VECTOR_ACK = 0;
    logic CCR_REQUEST_MASK = 0, BREAK_STATE = 0, low_req = 0, PREADY, PSLVERR, slv;
    logic IRQ_PIN_N, IRQ_REQ, VECTOR_SEL, WAKEUP;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    int n_errors = 0, checked = 0;
    always #25 CLK = ~CLK;
    eil_pin_model u_pin (.CLK(CLK), .low_req(low_req), .IRQ_PIN_N(IRQ_PIN_N));
    eil_top u_dut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ_PIN_N(IRQ_PIN_N), .VECTOR_ACK(VECTOR_ACK),
        .CCR_REQUEST_MASK(CCR_REQUEST_MASK), .BREAK_STATE(BREAK_STATE), .IRQ_REQ(IRQ_REQ),
        .VECTOR_SEL(VECTOR_SEL), .WAKEUP(WAKEUP));
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc
    task automatic wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // idle cycle after each transfer keeps the driver from double assigning
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            wrap_up();
        end
        rd = PRDATA;
        slv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CK(rd, e)
    endtask : rchk
    task automatic pin(input logic lo);
        low_req <= lo;
        cyc(6);
    endtask : pin
    initial begin
        cyc(12);
        ARST_N <= 1'b1;
        cyc(1);
        rchk(SC, 32'h0);
        rchk(SY, 32'h0);
        pin(1'b1);
        rchk(SC, 32'h0);
        pin(1'b0);
        $display("done reset and disabled pin");
        apb(1'b1, SY, 32'h1);
        pin(1'b1);
        rchk(SC, 32'h8);
        `CK({IRQ_REQ, VECTOR_SEL, WAKEUP}, 3'b111)
        CCR_REQUEST_MASK <= 1'b1;
        cyc(1);
        `CK({IRQ_REQ, WAKEUP}, 2'b01)
        CCR_REQUEST_MASK <= 1'b0;
        apb(1'b1, SC, 32'h2);
        `CK({IRQ_REQ, WAKEUP}, 2'b00)
        rchk(SC, 32'ha);
        apb(1'b1, SC, 32'h6);
        rchk(SC, 32'h2);
        pin(1'b0);
        apb(1'b1, SC, 32'h0);
        pin(1'b1);
        VECTOR_ACK <= 1'b1;
        cyc(1);
        VECTOR_ACK <= 1'b0;
        cyc(1);
        `CK(IRQ_REQ, 1'b0)
        pin(1'b0);
        pin(1'b1);
        `CK(IRQ_REQ, 1'b1)
        $display("done edge mode");
        apb(1'b1, SC, 32'h1);
        apb(1'b1, SC, 32'h5);
        rchk(SC, 32'h9);
        pin(1'b0);
        rchk(SC, 32'h1);
        pin(1'b1);
        pin(1'b0);
        rchk(SC, 32'h9);
        apb(1'b1, SC, 32'h5);
        rchk(SC, 32'h1);
        $display("done level mode");
        apb(1'b1, SC, 32'h0);
        pin(1'b1);
        BREAK_STATE <= 1'b1;
        apb(1'b1, SC, 32'h4);
        rchk(SC, 32'h8);
        apb(1'b1, SY, 32'h3);
        apb(1'b1, SC, 32'h4);
        BREAK_STATE <= 1'b0;
        rchk(SC, 32'h0);
        apb(1'b1, 12'h008, 32'hf);
        `CK(slv, 1'b1)
        $display("done break and unmapped");
        apb(1'b1, SC, 32'h1);
        ARST_N <= 1'b0;
        cyc(1);
        `CK(IRQ_REQ, 1'b0)
        ARST_N <= 1'b1;
        cyc(1);
        rchk(SC, 32'h0);
        $display("done second reset");
        wrap_up();
    end
endmodule : test_external_interrupt_latch
